// >>> rtl/host_iface_register_bank.sv
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - status 23/22 show transmit buffers full
// - status 21..18 show buffers empty
// - status 17 shows flash command busy
// - status 16 pending irq, bit0 enable
// - fixed part and maker codes
// - class code 0x48000, top byte reserved
// - fixed subsystem part and maker codes
// - header, revision, latency, grant bytes
// - mode bits 15:14 select mode register
// - mode bit 12 power-down exit type
// - write recovery codes 1..5 mean 2..6
// - bit 8 dll reset, bit 7 test
// - cas latency codes 3..6 valid
// - burst type bit3, length 4 or 8
// - timing fields in core cycles
// - load mode time and power-up delay
// - finish interrupt to processor after last
// - host notify: any data or first 64
// - direction bit selects memory to host
// - dma runs only while request set
// - six-bit linear buffer index
module host_iface_register_bank (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] address,
    input wire logic [31:0] writeData,
    input wire logic writeStrobe,
    input wire logic readStrobe,
    output logic [31:0] readData,
    input wire logic targetSendFull,
    input wire logic masterSendFull,
    input wire logic targetRecvEmpty,
    input wire logic targetSendEmpty,
    input wire logic masterRecvEmpty,
    input wire logic masterSendEmpty,
    input wire logic flashBusy,
    input wire logic hostIfaceEvent,
    input wire logic dmaTransferDone,
    input wire logic dmaFifoWordValid,
    output logic hostIrq,
    output logic [1:0] modeRegSelect,
    output logic powerDownExit,
    output logic [2:0] writeRecovery,
    output logic dllReset,
    output logic testModeSelect,
    output logic [2:0] casLatency,
    output logic burstOrdering,
    output logic [3:0] burstLength,
    output logic modeValid,
    output logic [31:0] timingPrimary,
    output logic [3:0] loadModeTime,
    output logic [15:0] powerUpDelay,
    output logic dmaEnable,
    output logic dmaToHost,
    output logic [5:0] linearBufferIndex,
    output logic dmaHostIrq,
    output logic dmaFinishIrq
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic irqEnable;
    logic irqPending;
    logic [31:0] modeValue;
    logic [31:0] timingSecondary;
    logic [31:0] dmaControl;
    logic [31:0] dmaCommand;
    logic finishArmed;
    logic [6:0] preparedCount;
    logic [31:0] next_readData;
    logic writeMode;
    logic writeDmaCtl;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction

    assign writeMode = writeStrobe && hit(address, hibank_pkg::ADDR_MODE);
    assign writeDmaCtl = writeStrobe && hit(address, hibank_pkg::ADDR_DMACTL);

    // ----------------------------------------
    // software writes
    // ----------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irqEnable <= hibank_pkg::IRQ_ENABLE_RESET;
        end else if (writeStrobe && hit(address, hibank_pkg::ADDR_STATUS)) begin
            irqEnable <= writeData[hibank_pkg::ST_IRQ_ENABLE];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            modeValue <= 32'h00000000;
            timingPrimary <= 32'h00000000;
            timingSecondary <= 32'h00000000;
            dmaCommand <= 32'h00000000;
        end else if (writeStrobe) begin
            // masks keep reserved bits zero
            if (writeMode) begin
                modeValue <= writeData & hibank_pkg::MODE_MASK;
            end
            if (hit(address, hibank_pkg::ADDR_TIMING0)) begin
                timingPrimary <= writeData;
            end
            if (hit(address, hibank_pkg::ADDR_TIMING1)) begin
                timingSecondary <= writeData & hibank_pkg::TIMING1_MASK;
            end
            if (hit(address, hibank_pkg::ADDR_DMACMD)) begin
                dmaCommand <= writeData & hibank_pkg::DMACMD_MASK;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dmaControl <= 32'h00000000;
        end else if (writeDmaCtl) begin
            dmaControl <= writeData & hibank_pkg::DMACTL_MASK;
        end
    end

    // ----------------------------------------
    // host interface interrupt
    // ----------------------------------------
    // pending is raw event level held until irq disabled; set wins
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irqPending <= 1'b0;
        end else if (hostIfaceEvent) begin
            irqPending <= 1'b1;
        end else if (!irqEnable) begin
            irqPending <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hostIrq <= 1'b0;
        end else begin
            hostIrq <= irqPending && irqEnable;
        end
    end

    // ----------------------------------------
    // mode value decode
    // ----------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            modeRegSelect <= 2'h0;
            powerDownExit <= 1'b0;
            writeRecovery <= 3'h0;
            dllReset <= 1'b0;
            testModeSelect <= 1'b0;
            casLatency <= 3'h0;
            burstOrdering <= 1'b0;
            burstLength <= 4'h0;
            modeValid <= 1'b0;
            loadModeTime <= 4'h0;
            powerUpDelay <= 16'h0000;
        end else begin
            modeRegSelect <= modeValue[15:14];
            powerDownExit <= modeValue[12];
            // recovery cycles = code + 1; 0 when reserved
            writeRecovery <= (modeValue[11:9] >= 3'h1 && modeValue[11:9] <= 3'h5) ?
                modeValue[11:9] + 3'h1 : 3'h0;
            dllReset <= modeValue[8];
            testModeSelect <= modeValue[7];
            casLatency <= (modeValue[6:4] >= 3'h3 && modeValue[6:4] <= 3'h6) ?
                modeValue[6:4] : 3'h0;
            burstOrdering <= modeValue[3];
            unique case (modeValue[2:0])
                3'h2: burstLength <= 4'h4;
                3'h3: burstLength <= 4'h8;
                default: burstLength <= 4'h0;
            endcase
            // flags a fully legal mode word for the memory controller
            modeValid <= (modeValue[11:9] >= 3'h1) && (modeValue[11:9] <= 3'h5) &&
                (modeValue[6:4] >= 3'h3) && (modeValue[6:4] <= 3'h6) &&
                (modeValue[2:1] == 2'h1);
            loadModeTime <= timingSecondary[19:16];
            powerUpDelay <= timingSecondary[15:0];
        end
    end

    // ----------------------------------------
    // firmware dma control
    // ----------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dmaEnable <= 1'b0;
            dmaToHost <= 1'b0;
            linearBufferIndex <= 6'h00;
        end else begin
            dmaEnable <= dmaControl[hibank_pkg::DMA_GO_BIT];
            dmaToHost <= dmaControl[hibank_pkg::DMA_DIR_BIT];
            linearBufferIndex <= dmaCommand[5:0];
        end
    end

    // armed when request drops with irq enabled; fires on last transfer
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            finishArmed <= 1'b0;
            dmaFinishIrq <= 1'b0;
        end else begin
            dmaFinishIrq <= 1'b0;
            if (writeDmaCtl && dmaControl[hibank_pkg::DMA_GO_BIT] &&
                !writeData[hibank_pkg::DMA_GO_BIT] &&
                writeData[hibank_pkg::DMA_IRQ_EN_BIT]) begin
                finishArmed <= 1'b1;
            end else if (finishArmed && dmaTransferDone) begin
                finishArmed <= 1'b0;
                dmaFinishIrq <= 1'b1;
            end
        end
    end

    // counts prepared words up to the first block threshold
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            preparedCount <= 7'h00;
        end else if (!dmaControl[hibank_pkg::DMA_GO_BIT]) begin
            preparedCount <= 7'h00;
        end else if (dmaFifoWordValid && preparedCount != hibank_pkg::FIRST_BLOCK_WORDS) begin
            preparedCount <= preparedCount + 7'h01;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dmaHostIrq <= 1'b0;
        end else if (!dmaControl[hibank_pkg::DMA_GO_BIT]) begin
            dmaHostIrq <= 1'b0;
        end else if (dmaControl[hibank_pkg::DMA_TYPE_BIT]) begin
            dmaHostIrq <= (preparedCount == hibank_pkg::FIRST_BLOCK_WORDS);
        end else begin
            dmaHostIrq <= dmaFifoWordValid;
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    always_comb begin
        next_readData = 32'h00000000;
        unique case (address)
            hibank_pkg::ADDR_STATUS: begin
                next_readData[hibank_pkg::ST_TGT_SEND_FULL] = targetSendFull;
                next_readData[hibank_pkg::ST_MASTER_SEND_FULL] = masterSendFull;
                next_readData[hibank_pkg::ST_TGT_RECV_EMPTY] = targetRecvEmpty;
                next_readData[hibank_pkg::ST_TGT_SEND_EMPTY] = targetSendEmpty;
                next_readData[hibank_pkg::ST_MASTER_RECV_EMPTY] = masterRecvEmpty;
                next_readData[hibank_pkg::ST_MASTER_SEND_EMPTY] = masterSendEmpty;
                next_readData[hibank_pkg::ST_FLASH_BUSY] = flashBusy;
                next_readData[hibank_pkg::ST_IRQ_PENDING] = irqPending;
                next_readData[hibank_pkg::ST_IRQ_ENABLE] = irqEnable;
            end
            hibank_pkg::ADDR_IDENT:
                next_readData = {hibank_pkg::PART_CODE, hibank_pkg::MAKER_CODE};
            hibank_pkg::ADDR_CLASS:
                next_readData = {8'h00, hibank_pkg::CLASS_CODE};
            hibank_pkg::ADDR_SUBSYS: next_readData = {hibank_pkg::SUBSYSTEM_PART_CODE,
                hibank_pkg::SUBSYSTEM_MAKER_CODE};
            hibank_pkg::ADDR_HEADER: next_readData = {hibank_pkg::HEADER_TYPE,
                hibank_pkg::REVISION_CODE, hibank_pkg::MAX_LATENCY,
                hibank_pkg::MIN_GRANT};
            hibank_pkg::ADDR_MODE: next_readData = modeValue;
            hibank_pkg::ADDR_TIMING0: next_readData = timingPrimary;
            hibank_pkg::ADDR_TIMING1: next_readData = timingSecondary;
            hibank_pkg::ADDR_DMACTL: next_readData = dmaControl;
            hibank_pkg::ADDR_DMACMD: next_readData = dmaCommand;
            default: next_readData = 32'h00000000; // unmapped reads zero
        endcase
    end

    // data valid only the cycle after the strobe; zero otherwise
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            readData <= 32'h00000000;
        end else if (readStrobe) begin
            readData <= next_readData;
        end else begin
            readData <= 32'h00000000;
        end
    end
endmodule
`default_nettype wire

// >>> shared/hibank_pkg.sv
`default_nettype none
package hibank_pkg;
    // ----------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_IDENT = 8'h04;
    localparam logic [7:0] ADDR_CLASS = 8'h08;
    localparam logic [7:0] ADDR_SUBSYS = 8'h0C;
    localparam logic [7:0] ADDR_HEADER = 8'h10;
    localparam logic [7:0] ADDR_MODE = 8'h14;
    localparam logic [7:0] ADDR_TIMING0 = 8'h18;
    localparam logic [7:0] ADDR_TIMING1 = 8'h1C;
    localparam logic [7:0] ADDR_DMACTL = 8'h24;
    localparam logic [7:0] ADDR_DMACMD = 8'h28;
    // ----------------------------------------
    // status bit positions
    // ----------------------------------------
    localparam int ST_TGT_SEND_FULL = 23;
    localparam int ST_MASTER_SEND_FULL = 22;
    localparam int ST_TGT_RECV_EMPTY = 21;
    localparam int ST_TGT_SEND_EMPTY = 20;
    localparam int ST_MASTER_RECV_EMPTY = 19;
    localparam int ST_MASTER_SEND_EMPTY = 18;
    localparam int ST_FLASH_BUSY = 17;
    localparam int ST_IRQ_PENDING = 16;
    localparam int ST_IRQ_ENABLE = 0;
    localparam logic IRQ_ENABLE_RESET = 1'b1;
    // ----------------------------------------
    // fixed identification (values arbitrary)
    // ----------------------------------------
    localparam logic [15:0] PART_CODE = 16'hA5C3;
    localparam logic [15:0] MAKER_CODE = 16'h5A3C;
    localparam logic [15:0] SUBSYSTEM_PART_CODE = 16'hA5C3;
    localparam logic [15:0] SUBSYSTEM_MAKER_CODE = 16'h5A3C;
    localparam logic [23:0] CLASS_CODE = 24'h048000;
    localparam logic [7:0] HEADER_TYPE = 8'h00;
    localparam logic [7:0] REVISION_CODE = 8'h01;
    localparam logic [7:0] MAX_LATENCY = 8'h00;
    localparam logic [7:0] MIN_GRANT = 8'h00;
    // ----------------------------------------
    // writable masks and field positions
    // ----------------------------------------
    localparam logic [31:0] MODE_MASK = 32'h0000DFFF;
    localparam logic [31:0] TIMING1_MASK = 32'h000FFFFF;
    localparam logic [31:0] DMACTL_MASK = 32'h80000007;
    localparam logic [31:0] DMACMD_MASK = 32'h0000003F;
    localparam int DMA_IRQ_EN_BIT = 31;
    localparam int DMA_TYPE_BIT = 2;
    localparam int DMA_DIR_BIT = 1;
    localparam int DMA_GO_BIT = 0;
    localparam logic [6:0] FIRST_BLOCK_WORDS = 7'h40;
endpackage
`default_nettype wire

// >>> sim/hibank_dma_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// dma engine stand-in
// ------------------------------
module hibank_dma_peer (
    input wire logic clock,
    input wire logic rst,
    input wire logic dmaEnable,
    output logic dmaFifoWordValid,
    output logic dmaTransferDone
);
    logic wasEnabled;
    // a word each cycle: fastest fill, worst case for the 64 count
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dmaFifoWordValid <= 1'b0;
            wasEnabled <= 1'b0;
            dmaTransferDone <= 1'b0;
        end else begin
            dmaFifoWordValid <= dmaEnable;
            wasEnabled <= dmaEnable;
            dmaTransferDone <= wasEnabled & ~dmaEnable;
        end
    end
endmodule
`default_nettype wire

// >>> sim/hibank_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// register bank checks
// ------------------------------
module hibank_checker (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] address,
    input wire logic readStrobe,
    input wire logic [31:0] readData,
    input wire logic targetSendFull,
    input wire logic masterSendFull,
    input wire logic targetRecvEmpty,
    input wire logic targetSendEmpty,
    input wire logic masterRecvEmpty,
    input wire logic masterSendEmpty,
    input wire logic flashBusy,
    input wire logic dmaTransferDone,
    input wire logic dmaFinishIrq,
    input wire logic [2:0] writeRecovery,
    input wire logic [2:0] casLatency,
    input wire logic [3:0] burstLength,
    input wire logic modeValid
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    sequence readAt(logic [7:0] a);
        readStrobe && address == a;
    endsequence
    chk_class_code: assert property (
        readAt(hibank_pkg::ADDR_CLASS) |=> readData == 32'h00048000)
        else $error("class code read wrong");
    chk_status_live: assert property (
        readAt(hibank_pkg::ADDR_STATUS) |=> readData[23:17] == $past({targetSendFull,
        masterSendFull, targetRecvEmpty, targetSendEmpty, masterRecvEmpty,
        masterSendEmpty, flashBusy})) else $error("status flags wrong");
    chk_status_rsvd: assert property (
        readAt(hibank_pkg::ADDR_STATUS) |=> readData[31:24] == 8'h00 && readData[15:1] == 15'h0)
        else $error("status reserved bits set");
    chk_read_idle: assert property (
        !readStrobe |=> readData == 32'h0) else $error("read data outside slot");
    chk_finish_pulse: assert property (
        dmaFinishIrq |-> $past(dmaTransferDone) ##1 !dmaFinishIrq)
        else $error("finish pulse wrong");
    chk_mode_valid: assert property (
        modeValid == (writeRecovery != 3'h0 && casLatency != 3'h0 && burstLength != 4'h0))
        else $error("mode valid wrong");
    chk_cas_range: assert property (
        casLatency == 3'h0 || (casLatency >= 3'h3 && casLatency <= 3'h6))
        else $error("cas latency out of range");
    chk_burst_len: assert property (
        burstLength inside {4'h0, 4'h4, 4'h8}) else $error("burst length illegal");
endmodule
bind host_iface_register_bank hibank_checker chk_u (.clock, .rst, .address, .readStrobe,
    .readData, .targetSendFull, .masterSendFull, .targetRecvEmpty, .targetSendEmpty,
    .masterRecvEmpty, .masterSendEmpty, .flashBusy, .dmaTransferDone, .dmaFinishIrq,
    .writeRecovery, .casLatency, .burstLength, .modeValid);
`default_nettype wire

// >>> sim/host_iface_register_bank_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin badCount++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
// ------------------------------
// bench
// ------------------------------
module host_iface_register_bank_tb_top;
    logic clock, rst, writeStrobe, readStrobe, hostIfaceEvent, hostIrq, modeValid;
    logic [7:0] address;
    logic [31:0] writeData, readData, timingPrimary;
    logic [6:0] flags;
    logic [1:0] modeRegSelect;
    logic [2:0] writeRecovery, casLatency, c;
    logic [3:0] burstLength, loadModeTime, finishCount;
    logic [15:0] powerUpDelay;
    logic [5:0] linearBufferIndex;
    logic powerDownExit, dllReset, testModeSelect, burstOrdering, dmaEnable, dmaToHost;
    logic dmaHostIrq, dmaFinishIrq, dmaTransferDone, dmaFifoWordValid;
    int badCount, numChecks, cycles;
    host_iface_register_bank dut_u (.clock, .rst, .address, .writeData, .writeStrobe,
        .readStrobe, .readData, .targetSendFull(flags[6]), .masterSendFull(flags[5]),
        .targetRecvEmpty(flags[4]), .targetSendEmpty(flags[3]), .masterRecvEmpty(flags[2]),
        .masterSendEmpty(flags[1]), .flashBusy(flags[0]), .hostIfaceEvent, .dmaTransferDone,
        .dmaFifoWordValid, .hostIrq, .modeRegSelect, .powerDownExit, .writeRecovery,
        .dllReset, .testModeSelect, .casLatency, .burstOrdering, .burstLength, .modeValid,
        .timingPrimary, .loadModeTime, .powerUpDelay, .dmaEnable, .dmaToHost,
        .linearBufferIndex, .dmaHostIrq, .dmaFinishIrq);
    hibank_dma_peer peer_u (.clock, .rst, .dmaEnable, .dmaFifoWordValid, .dmaTransferDone);
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic testDone();
        if (badCount == 0 && numChecks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // hang guard, run needs well under a thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (finishCount != 4'hF && dmaFinishIrq === 1'b1) finishCount <= finishCount + 4'h1;
        if (cycles == 3000) begin
            badCount++;
            testDone();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        address <= a;
        writeData <= d;
        writeStrobe <= 1'b1;
        @(posedge clock);
        writeStrobe <= 1'b0;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        address <= a;
        readStrobe <= 1'b1;
        @(posedge clock);
        readStrobe <= 1'b0;
        #1;
        `CHK(readData, e)
    endtask
    initial begin
        {rst, writeStrobe, readStrobe, hostIfaceEvent, address, writeData, flags} = '0;
        finishCount = 4'h0;
        rst = 1'b1;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        rdChk(hibank_pkg::ADDR_CLASS, {8'h00, hibank_pkg::CLASS_CODE});
        rdChk(hibank_pkg::ADDR_IDENT, {hibank_pkg::PART_CODE, hibank_pkg::MAKER_CODE});
        rdChk(hibank_pkg::ADDR_SUBSYS, {hibank_pkg::SUBSYSTEM_PART_CODE,
            hibank_pkg::SUBSYSTEM_MAKER_CODE});
        rdChk(hibank_pkg::ADDR_HEADER, {hibank_pkg::HEADER_TYPE, hibank_pkg::REVISION_CODE,
            hibank_pkg::MAX_LATENCY, hibank_pkg::MIN_GRANT});
        for (int p = 0; p < 2; p++) begin
            flags <= p ? 7'h2A : 7'h55;
            rdChk(hibank_pkg::ADDR_STATUS, {8'h00, p ? 7'h2A : 7'h55, 17'h00001});
        end
        wr(hibank_pkg::ADDR_CLASS, 32'hFFFFFFFF);
        rdChk(hibank_pkg::ADDR_CLASS, 32'h00048000);
        rdChk(8'h20, 32'h0);
        hostIfaceEvent <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
        `CHK(hostIrq, 1'b1)
        hostIfaceEvent <= 1'b0;
        rdChk(hibank_pkg::ADDR_STATUS, {8'h00, 7'h2A, 17'h10001});
        wr(hibank_pkg::ADDR_STATUS, 32'h0);
        rdChk(hibank_pkg::ADDR_STATUS, {8'h00, 7'h2A, 17'h00000});
        `CHK(hostIrq, 1'b0)
        wr(hibank_pkg::ADDR_STATUS, 32'h1);
        for (int n = 0; n < 8; n++) begin
            c = n[2:0];
            wr(hibank_pkg::ADDR_MODE, {16'hFFFF, c[1:0], 1'b1, c[0], c, c[1], c[2], c, c[0], c});
            rdChk(hibank_pkg::ADDR_MODE, {16'h0, c[1:0], 1'b0, c[0], c, c[1], c[2], c, c[0], c});
            `CHK(modeRegSelect, c[1:0])
            `CHK(powerDownExit, c[0])
            `CHK(writeRecovery, (c >= 3'h1 && c <= 3'h5) ? 3'(c + 3'h1) : 3'h0)
            `CHK({dllReset, testModeSelect}, {c[1], c[2]})
            `CHK(casLatency, (c >= 3'h3 && c <= 3'h6) ? c : 3'h0)
            `CHK(burstOrdering, c[0])
            `CHK(burstLength, c == 3'h2 ? 4'h4 : (c == 3'h3 ? 4'h8 : 4'h0))
            `CHK(modeValid, c == 3'h3)
        end
        wr(hibank_pkg::ADDR_TIMING0, 32'hA5C3F00F);
        rdChk(hibank_pkg::ADDR_TIMING0, 32'hA5C3F00F);
        `CHK(timingPrimary, 32'hA5C3F00F)
        wr(hibank_pkg::ADDR_TIMING1, 32'hFFF5ABCD);
        rdChk(hibank_pkg::ADDR_TIMING1, 32'h0005ABCD);
        `CHK({loadModeTime, powerUpDelay}, 20'h5ABCD)
        wr(hibank_pkg::ADDR_DMACMD, 32'hFFFFFFEA);
        rdChk(hibank_pkg::ADDR_DMACMD, 32'h0000002A);
        `CHK(linearBufferIndex, 6'h2A)
        `CHK({dmaEnable, dmaHostIrq}, 2'h0)
        wr(hibank_pkg::ADDR_DMACTL, 32'hFFFFFFFB);
        rdChk(hibank_pkg::ADDR_DMACTL, 32'h80000003);
        // peer word already out; irq registers on the next edge, second edge spare
        repeat (2) @(posedge clock);
        #1;
        `CHK({dmaEnable, dmaToHost, dmaHostIrq}, 3'h7)
        wr(hibank_pkg::ADDR_DMACTL, 32'h0);
        repeat (4) @(posedge clock);
        #1;
        `CHK({dmaEnable, dmaHostIrq}, 2'h0)
        wr(hibank_pkg::ADDR_DMACTL, 32'h80000005);
        repeat (40) @(posedge clock);
        #1;
        `CHK({dmaEnable, dmaToHost, dmaHostIrq}, 3'h4)
        repeat (40) @(posedge clock);
        #1;
        `CHK(dmaHostIrq, 1'b1)
        wr(hibank_pkg::ADDR_DMACTL, 32'h80000004);
        repeat (10) @(posedge clock);
        #1;
        `CHK(finishCount, 4'h1)
        testDone();
    end
endmodule
`default_nettype wire
